//--- sim/rps_det_model.sv
`default_nettype none
`include "rps_regs.svh"
module rps_det_model
  import rps_pkg::*;
(
  input wire logic clk,
  input wire logic [`RPS_NDET-1:0] smoke_set,
  input wire logic [`RPS_NDET-1:0] heat_set,
  output rps_det_t det
);
  timeunit 1ns;
  timeprecision 1ns;
  // contacts follow the set lines one edge late; the nonblocking update keeps
  // the bench's falling-edge writes and the design's sampling free of races
  always @(posedge clk)
    det <= '{smoke: smoke_set, overheat: heat_set};
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none
module tb_top
  import rps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 4;
  localparam logic [39:0] ALL = '1;
  logic clk = 0;
  logic rst_b = 0;
  logic button = 0;
  logic tcc = 1;
  logic [23:0] sm = '0;
  logic [23:0] ht = '0;
  rps_det_t det;
  logic [39:0] relay;
  logic beeper, green_led, status_led, ftm;
  logic [23:0] latch;
  logic [4:0] mon;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  assign mon = {relay[39], relay[1], relay[0], green_led, beeper};
  rps_det_model i_det (.clk(clk), .smoke_set(sm), .heat_set(ht), .det(det));
  rps_top #(.QTR_CYC(Q)) i_dut (.clk(clk), .rst_b(rst_b), .button(button),
    .test_contact_closed(tcc), .det(det), .relay(relay), .beeper(beeper),
    .green_led(green_led), .status_led(status_led), .fast_test_mode(ftm),
    .smoke_latch(latch));
  initial forever #10 clk = ~clk;
  task automatic chk(input string w, input logic [39:0] s, input logic [39:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // cycles that mon[b] keeps value v; bounded so a stuck output cannot hang
  task automatic hold(input int b, input logic v, output int k);
    k = 0;
    while (mon[b] === v && k < 2000)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic press();
    button = 1;
    tick(2);
    button = 0;
    tick(1);
  endtask
  // rising beeper edges over one whole alarm period
  task automatic beeps(output int k);
    logic p;
    p = beeper;
    k = 0;
    repeat (20 * Q)
    begin
      @(negedge clk);
      if (beeper && !p)
        k++;
      p = beeper;
    end
  endtask
  task automatic t_ready();
    hold(0, 0, n);
    hold(0, 1, n);
    chk("beep1", 40'(n), 40'(2 * Q));
    hold(0, 0, n);
    chk("gap", 40'(n), 40'(Q));
    hold(0, 1, n);
    chk("beep2", 40'(n), 40'(Q));
    hold(1, 0, n);
    hold(1, 1, n);
    chk("lamp_on", 40'(n), 40'(Q));
    hold(1, 0, n);
    chk("lamp_off", 40'(n), 40'(Q));
  endtask
  // start up at normal pace, smoke ignored, then abort
  task automatic t_abort();
    press();
    hold(2, 0, n);
    chk("first_on", relay, 40'h1);
    sm[0] = 1'b1;
    hold(3, 0, n);
    chk("step_norm", 40'(n), 40'(4 * Q + 1));
    chk("no_watch", 40'(latch), 40'h0);
    sm[0] = 1'b0;
    press();
    hold(3, 1, n);
    hold(2, 1, n);
    chk("down_step", 40'(n), 40'(2 * Q + 1));
    chk("aborted", relay, 40'h0);
  endtask
  task automatic t_fast_up();
    hold(1, 0, n);
    tcc = 1'b0;
    tick(2);
    chk("fast", 40'(ftm), 40'h1);
    press();
    hold(2, 0, n);
    hold(3, 0, n);
    chk("step_fast", 40'(n), 40'(2 * Q + 1));
    hold(4, 0, n);
    tick(2);
    chk("all_on", relay, ALL);
    chk("status", 40'(status_led), 40'h1);
  endtask
  // alarms in fast test; det2 and det3 share relays 19..22
  task automatic t_alarms();
    ht[5] = 1'b1;
    tick(2);
    beeps(n);
    chk("heat_beeps", 40'(n), 40'h2);
    chk("heat_keeps", relay, ALL);
    sm[2] = 1'b1;
    tick(4);
    chk("cut", relay, ~(40'hf << 19));
    chk("latch", 40'(latch), 40'h4);
    beeps(n);
    chk("both_beeps", 40'(n), 40'h3);
    ht[5] = 1'b0;
    sm[3] = 1'b1;
    sm[2] = 1'b0;
    tick(4);
    chk("shared", relay, ~(40'hf << 19));
    beeps(n);
    chk("smoke_beeps", 40'(n), 40'h3);
    sm[3] = 1'b0;
    tick(4);
    chk("restored", relay, ALL);
  endtask
  // outside test the cut holds, then the bank steps down from the top
  task automatic t_latch_down();
    tcc = 1'b1;
    tick(2);
    sm[0] = 1'b1;
    tick(4);
    sm[0] = 1'b0;
    tick(6);
    chk("held_off", relay, ~(40'h1 << 15));
    press();
    hold(4, 1, n);
    chk("top_first", relay, 40'h7f_ffff_7fff);
    hold(2, 1, n);
    tick(2);
    chk("all_off", relay, 40'h0);
    chk("cleared", 40'(latch), 40'h0);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    tick(4);
    rst_b = 1'b1;
    t_ready();
    t_abort();
    t_fast_up();
    t_alarms();
    t_latch_down();
    wrap_up();
  end
  // whole run needs little more than a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire

//--- verilog/rps_pkg.sv
`default_nettype none
`include "rps_regs.svh"
package rps_pkg;
  typedef logic [`RPS_NDET-1:0][`RPS_NREL-1:0] rps_map_t;

  // one-hot sequencer states
  typedef enum logic [5:0] {
    S_INIT = 6'h01,
    S_READY = 6'h02,
    S_IDLE = 6'h04,
    S_UP = 6'h08,
    S_RUN = 6'h10,
    S_DOWN = 6'h20
  } rps_state_t;

  // detector contacts, one bit per detector, high while alarming
  typedef struct packed {
    logic [`RPS_NDET-1:0] smoke;
    logic [`RPS_NDET-1:0] overheat;
  } rps_det_t;

  // example groups: shared groups may be named by several detectors
  function automatic rps_map_t rps_default_map();
    rps_map_t m;
    m = '0;
    m[0][15] = 1'b1;
    m[1][16] = 1'b1;
    m[2][22:19] = 4'hf;
    m[3][22:19] = 4'hf;
    m[12][8:5] = 4'hf;
    m[14][30:28] = 3'h7;
    m[17][25:23] = 3'h7;
    return m;
  endfunction
endpackage
`default_nettype wire

//--- verilog/rps_regs.svh
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// bank sizes
`define RPS_NREL 40
`define RPS_NDET 24

// clock rate and the quarter-second base tick
`define RPS_CLK_HZ 50000000
`define RPS_QTR_MS 250
`define RPS_QTR_CYC (`RPS_QTR_MS * (`RPS_CLK_HZ / 1000))

// times in ms, and the same figures in quarter ticks
`define RPS_READY_ON1_MS 500
`define RPS_READY_OFF_MS 250
`define RPS_READY_ON2_MS 250
`define RPS_STEP_NORM_MS 1000
`define RPS_STEP_FAST_MS 500
`define RPS_STEP_DOWN_MS 500
`define RPS_ALARM_PERIOD_MS 5000
`define RPS_BEEP_MS 250
`define RPS_READY_ON1_Q (`RPS_READY_ON1_MS / `RPS_QTR_MS)
`define RPS_READY_END_Q ((`RPS_READY_ON1_MS + `RPS_READY_OFF_MS) / `RPS_QTR_MS)
`define RPS_READY_LEN_Q ((`RPS_READY_ON1_MS + `RPS_READY_OFF_MS + `RPS_READY_ON2_MS) / `RPS_QTR_MS)
`define RPS_STEP_NORM_Q (`RPS_STEP_NORM_MS / `RPS_QTR_MS)
`define RPS_STEP_FAST_Q (`RPS_STEP_FAST_MS / `RPS_QTR_MS)
`define RPS_STEP_DOWN_Q (`RPS_STEP_DOWN_MS / `RPS_QTR_MS)
`define RPS_ALARM_PERIOD_Q (`RPS_ALARM_PERIOD_MS / `RPS_QTR_MS)
`define RPS_BEEP_Q (`RPS_BEEP_MS / `RPS_QTR_MS)

`endif

//--- verilog/rps_top.sv
// How it works
// - an active smoke alarm switches off every relay mapped to that detector
// - one detector may cut a group; several detectors may cut one shared group
// - overheat alone never removes relay power, it only sounds the beeper
// - ready beep: half second on, quarter off, quarter on
// - while waiting, the green button lamp toggles every quarter second
// - a press while idle starts switching relays on upward from the first
// - a press during switch-on aborts and steps the lit relays back off
// - switch-on steps are one second apart, half a second in fast test
// - detectors are watched only after switch-on completes, the run mode
// - in run mode the status lamp is steadily lit
// - overheat without smoke gives two beeps every five seconds
// - smoke gives three beeps every five seconds and cuts mapped relays
// - smoke with overheat uses three beeps and still cuts mapped relays
// - a press in run mode steps relays off downward, half a second apart
// - fast test mode holds while the test contact reads open
// - in fast test a cleared smoke alarm restores its relays by itself
// - alarm watching runs apart from the on/off sequencer
`default_nettype none
`include "rps_regs.svh"
module rps_top
  import rps_pkg::*;
#(
  parameter int QTR_CYC = `RPS_QTR_CYC,
  parameter rps_map_t SMOKE_MAP = rps_default_map()
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic button,
  input wire logic test_contact_closed,
  input wire rps_det_t det,
  output logic [`RPS_NREL-1:0] relay,
  output logic beeper,
  output logic green_led,
  output logic status_led,
  output logic fast_test_mode,
  output logic [`RPS_NDET-1:0] smoke_latch
);
  localparam int NREL = `RPS_NREL;
  localparam int NDET = `RPS_NDET;
  localparam int QW = $clog2(QTR_CYC + 1);

  logic rst_s1;
  logic rst_n;
  logic [QW-1:0] qdiv;
  logic [4:0] rq;
  logic [4:0] aq;
  logic [2:0] step_q;
  logic [5:0] cnt;
  logic [NREL-1:0] seq_on;
  logic [NREL-1:0] cut;
  logic btn_q;
  rps_state_t st;
  rps_state_t next_st;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // decode of the sequencer's view
  wire press = button & ~btn_q;
  wire mon = (st == S_RUN);
  wire qtr_hit = (qdiv == QW'(QTR_CYC - 1));
  wire up_go = (st == S_UP) & ~press & (cnt != 6'(NREL));
  wire dn_go = (st == S_DOWN) & (cnt != 6'h00);
  wire step_fire = (step_q == 3'h0) & (up_go | dn_go);
  wire [2:0] up_dly = fast_test_mode ? 3'(`RPS_STEP_FAST_Q) : 3'(`RPS_STEP_NORM_Q);
  wire [2:0] dly = (st == S_UP) ? up_dly : 3'(`RPS_STEP_DOWN_Q);
  // restarting the divider on each step makes every delay whole quarters plus one cycle
  wire qclr = (st == S_INIT) | step_fire;

  // alarm watching side: gated live inputs drive the beep code
  wire [NDET-1:0] smoke_act = det.smoke & {NDET{mon}};
  wire smoke_any = |smoke_act;
  wire oh_any = |(det.overheat & {NDET{mon}});
  // three beeps for smoke even with overheat, two for overheat alone
  wire [2:0] nbeep = smoke_any ? 3'h3 : (oh_any ? 3'h2 : 3'h0);
  // beeps sound on the even quarters 0, 2 and, with three beeps, 4 of the period
  wire alarm_beep = (aq < 5'(2 * nbeep)) & ~aq[0];
  wire ready_beep = (rq != 5'(`RPS_READY_ON1_Q)) & (rq < 5'(`RPS_READY_LEN_Q));
  wire keep_latch = (st == S_RUN) | (st == S_DOWN);
  // in test mode a latch drops once its detector clears; a fresh set wins
  wire [NDET-1:0] lat_clr = fast_test_mode ? ~det.smoke : '0;
  wire [NDET-1:0] next_lat = keep_latch ? ((smoke_latch & ~lat_clr) | smoke_act) : '0;

  // detector to relay map: any latched detector cuts its whole group
  always_comb
  begin
    cut = '0;
    for (int d = 0; d < NDET; d++)
    begin
      cut = cut | (SMOKE_MAP[d] & {NREL{smoke_latch[d]}});
    end
  end

  // sequencer next state
  always_comb
  begin
    next_st = st;
    unique case (st)
      S_INIT: next_st = S_READY;
      S_READY:
      begin
        if (qtr_hit && rq == 5'(`RPS_READY_LEN_Q - 1))
        begin
          next_st = S_IDLE;
        end
      end
      S_IDLE:
      begin
        if (press)
        begin
          next_st = S_UP;
        end
      end
      S_UP:
      begin
        if (press && cnt != 6'h00)
        begin
          next_st = S_DOWN;
        end
        else if (cnt == 6'(NREL))
        begin
          next_st = S_RUN;
        end
      end
      S_RUN:
      begin
        if (press)
        begin
          next_st = S_DOWN;
        end
      end
      S_DOWN:
      begin
        if (cnt == 6'h00)
        begin
          next_st = S_IDLE;
        end
      end
      default: next_st = S_INIT;
    endcase
  end

  // quarter-second divider
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      qdiv <= '0;
    else if (qclr || qtr_hit)
      qdiv <= '0;
    else
      qdiv <= qdiv + 1'b1;
  end

  // state, button edge and the ready-pattern counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= S_INIT;
      btn_q <= 1'b0;
      rq <= '0;
    end
    else
    begin
      st <= next_st;
      btn_q <= button;
      if (st == S_READY && qtr_hit)
        rq <= rq + 5'h01;
    end
  end

  // relay stepping: index counter doubles as count of lit relays
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_on <= '0;
      cnt <= '0;
      step_q <= '0;
    end
    else
    begin
      if (step_fire && st == S_UP)
      begin
        seq_on[cnt] <= 1'b1;
        cnt <= cnt + 6'h01;
      end
      else if (step_fire)
      begin
        seq_on[cnt - 6'h01] <= 1'b0;
        cnt <= cnt - 6'h01;
      end
      if (st != S_UP && st != S_DOWN)
        step_q <= '0;
      else if (step_fire)
        step_q <= dly;
      else if (qtr_hit && step_q != 3'h0)
        step_q <= step_q - 3'h1;
    end
  end

  // alarm side runs on its own, reading only whether the sequencer is in S_RUN or S_DOWN
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smoke_latch <= '0;
      aq <= '0;
    end
    else
    begin
      smoke_latch <= next_lat;
      if (nbeep == 3'h0)
        aq <= '0;
      else if (qtr_hit)
        aq <= (aq == 5'(`RPS_ALARM_PERIOD_Q - 1)) ? 5'h00 : aq + 5'h01;
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      relay <= '0;
      beeper <= 1'b0;
      green_led <= 1'b0;
      status_led <= 1'b0;
      fast_test_mode <= 1'b0;
    end
    else
    begin
      relay <= seq_on & ~cut;
      beeper <= (st == S_READY) ? ready_beep : alarm_beep;
      if (st != S_IDLE)
        green_led <= 1'b0;
      else if (qtr_hit)
        green_led <= ~green_led;
      status_led <= (st == S_RUN);
      fast_test_mode <= ~test_contact_closed;
    end
  end

  property p_cut;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((relay & $past(cut)) == '0);
  endproperty
  a_cut: assert property (p_cut) else $error("mapped relay left on under smoke");

  property p_heat_only;
    @(posedge clk) disable iff (!rst_n)
    (smoke_latch == '0) |=> (relay == $past(seq_on));
  endproperty
  a_heat_only: assert property (p_heat_only) else $error("relay cut without smoke");

  property p_flash;
    @(posedge clk) disable iff (!rst_n)
    (st == S_IDLE && next_st == S_IDLE && qtr_hit) |=> (green_led != $past(green_led));
  endproperty
  a_flash: assert property (p_flash) else $error("green lamp did not toggle");

  property p_start;
    @(posedge clk) disable iff (!rst_n)
    (st == S_IDLE && press) |=> ##1 seq_on[0] ##1 relay[0];
  endproperty
  a_start: assert property (p_start) else $error("first relay not switched on");

  property p_abort;
    @(posedge clk) disable iff (!rst_n)
    (st == S_UP && press && cnt != 6'h00) |=> (st == S_DOWN);
  endproperty
  a_abort: assert property (p_abort) else $error("switch-on not aborted");

  property p_lamp;
    @(posedge clk) disable iff (!rst_n)
    (st == S_RUN) |=> status_led;
  endproperty
  a_lamp: assert property (p_lamp) else $error("status lamp not lit in run");

  property p_done;
    @(posedge clk) disable iff (!rst_n)
    (st == S_UP && cnt == 6'(NREL) && !press) |=> (st == S_RUN && seq_on == '1);
  endproperty
  a_done: assert property (p_done) else $error("run not entered with all relays");

  property p_down_step;
    @(posedge clk) disable iff (!rst_n)
    (step_fire && st == S_DOWN) |=> (cnt == $past(cnt) - 6'h01) && !seq_on[cnt];
  endproperty
  a_down_step: assert property (p_down_step) else $error("off step wrong");

  property p_no_watch;
    @(posedge clk) disable iff (!rst_n)
    (st == S_IDLE || st == S_UP) |=> (smoke_latch == '0);
  endproperty
  a_no_watch: assert property (p_no_watch) else $error("alarm latched before run");
endmodule
`default_nettype wire
